// ===== afs_pkg.sv
package afs_pkg;
  // Register word addresses on the device's configuration port.
  localparam logic [7:0] ADDR_CALIB_FORMAT = 8'h0D;
  localparam logic [7:0] ADDR_GAIN_CAL_A   = 8'h33;
  localparam logic [7:0] ADDR_GAIN_CAL_B   = 8'h34;
  localparam logic [7:0] ADDR_REF_POWER    = 8'hC1;
  localparam logic [7:0] ADDR_SPAN_LO      = 8'hC2;
  localparam logic [7:0] ADDR_SPAN_HI      = 8'hC3;
  // Field positions in the calibration and format word.
  localparam int BIT_GAIN_CAL_1  = 0;
  localparam int BIT_FORMAT      = 1;
  localparam int BIT_WIDE_CM     = 2;
  localparam int BIT_CM_ON_A     = 3;
  localparam int POS_CM_SPAN_A   = 4;
  localparam int BIT_CM_ON_B     = 6;
  localparam int POS_CM_SPAN_B   = 7;
  // Gain calibration words and reference word.
  localparam int BIT_GAIN_CAL_2  = 0;
  localparam int BIT_GAIN_CAL_3  = 1;
  localparam int BIT_GAIN_CAL_4  = 0;
  localparam int BIT_REF_OFF     = 0;
  // Reset values.
  localparam logic [15:0] RST_CALIB_FORMAT = 16'h0000;
  localparam logic [15:0] RST_GAIN_CAL     = 16'h0000;
  localparam logic [15:0] RST_REF_POWER    = 16'h0000;
  localparam logic [15:0] RST_SPAN         = 16'h0000;
  // Span codes, largest first.
  localparam logic [2:0] SPAN_12V  = 3'h5;
  localparam logic [2:0] SPAN_10V  = 3'h4;
  localparam logic [2:0] SPAN_7V   = 3'h3;
  localparam logic [2:0] SPAN_5V   = 3'h0;
  localparam logic [2:0] SPAN_3V5  = 3'h1;
  localparam logic [2:0] SPAN_2V5  = 3'h2;
  // Common-mode span field codes.
  localparam logic [1:0] CM_HALF   = 2'h0;
  localparam logic [1:0] CM_WIDEST = 2'h1;
  localparam logic [1:0] CM_MID    = 2'h2;
  // Frame and timing.
  localparam int NUM_CH          = 4;
  localparam int CODE_BITS       = 18;
  localparam int SYNC_TO_FRAME   = 3;
  localparam int STARTUP_PERIODS = 16;
  // Host controller register offsets (bytes) on the Avalon-MM slave.
  localparam logic [3:0] HOST_CTRL   = 4'h0;
  localparam logic [3:0] HOST_DIV    = 4'h4;
  localparam logic [3:0] HOST_CFG    = 4'h8;
  localparam logic [3:0] HOST_STATUS = 4'hC;
  localparam logic [15:0] RST_DIV    = 16'h0004;
endpackage

// ===== afs_if.sv
`timescale 1ns/1ps
interface afs_if;
  logic        conversion_clock_in;
  logic        sample_align_in;
  logic        cfg_we;
  logic [7:0]  cfg_addr;
  logic [15:0] cfg_wdata;
  logic [15:0] cfg_rdata;
  logic        frame_clock_out;
  logic        out_valid;
  logic [2:0]  channel_idx;
  modport dev  (input conversion_clock_in, sample_align_in, cfg_we, cfg_addr, cfg_wdata,
                output cfg_rdata, frame_clock_out, out_valid, channel_idx);
  modport host (output conversion_clock_in, sample_align_in, cfg_we, cfg_addr, cfg_wdata,
                input cfg_rdata, frame_clock_out, out_valid, channel_idx);
endinterface

// ===== afs_device.sv
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
module afs_device (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic clk_en,
  // Link to host
  afs_if.dev        lnk,
  // Effective settings for the converter core
  output logic      twos_comp,
  output logic      gain_cal_active,
  output logic      ref_enabled,
  output logic      wide_cm,
  output logic [2:0] cm_sel_a,
  output logic [2:0] cm_sel_b,
  output logic [23:0] span_codes
);
  import afs_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  logic [2:0] clk_s_q;
  logic [2:0] sync_s_q;
  wire  cclk_fall = clk_s_q[2] & ~clk_s_q[1];
  wire  cclk_rise = clk_s_q[1] & ~clk_s_q[2];
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clk_s_q  <= 3'h0;
      sync_s_q <= 3'h0;
    end else if (clk_en) begin
      clk_s_q  <= {clk_s_q[1:0], lnk.conversion_clock_in};
      sync_s_q <= {sync_s_q[1:0], lnk.sample_align_in};
    end
  end
  // Sync is taken as the settled level at a falling clock edge.
  wire sync_evt = cclk_fall & sync_s_q[1] & sync_s_q[2];
  ////////////////////////////////////////////////////////////////////////////////
  // One-hot register select. Write and read paths share it, so they can never
  // disagree on which word an address names. Unknown addresses select nothing.
  function automatic logic [5:0] reg_select(input logic [7:0] addr);
    logic [5:0] sel;
    sel = 6'h00;
    if (addr == ADDR_CALIB_FORMAT) sel = 6'h01;
    else if (addr == ADDR_GAIN_CAL_A) sel = 6'h02;
    else if (addr == ADDR_GAIN_CAL_B) sel = 6'h04;
    else if (addr == ADDR_REF_POWER) sel = 6'h08;
    else if (addr == ADDR_SPAN_LO) sel = 6'h10;
    else if (addr == ADDR_SPAN_HI) sel = 6'h20;
    return sel;
  endfunction
  logic [15:0] calfmt_q;
  logic [15:0] gca_q;
  logic [15:0] gcb_q;
  logic [15:0] ref_q;
  logic [15:0] span_lo_q;
  logic [15:0] span_hi_q;
  wire  [5:0]  sel = reg_select(lnk.cfg_addr);
  wire         wr  = lnk.cfg_we & clk_en;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      calfmt_q  <= RST_CALIB_FORMAT;
      gca_q     <= RST_GAIN_CAL;
      gcb_q     <= RST_GAIN_CAL;
      ref_q     <= RST_REF_POWER;
      span_lo_q <= RST_SPAN;
      span_hi_q <= RST_SPAN;
    end else if (wr) begin
      if (sel[0]) calfmt_q <= lnk.cfg_wdata;
      if (sel[1]) gca_q <= lnk.cfg_wdata;
      if (sel[2]) gcb_q <= lnk.cfg_wdata;
      if (sel[3]) ref_q <= lnk.cfg_wdata;
      if (sel[4]) span_lo_q <= lnk.cfg_wdata;
      if (sel[5]) span_hi_q <= lnk.cfg_wdata;
    end
  end
  logic [15:0] rd_d;
  always_comb begin
    if (sel[0]) rd_d = calfmt_q;
    else if (sel[1]) rd_d = gca_q;
    else if (sel[2]) rd_d = gcb_q;
    else if (sel[3]) rd_d = ref_q;
    else if (sel[4]) rd_d = span_lo_q;
    else if (sel[5]) rd_d = span_hi_q;
    else rd_d = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer: four channel slots per converter, one per conversion clock.
  // Without sync the starting slot is whatever reset left, which is allowed.
  logic [1:0] ch_q;
  logic [1:0] dly_q;
  logic       pend_q;
  logic       aligned_q;
  logic [4:0] up_q;
  logic       frame_q;
  wire  dly_done = pend_q & (dly_q == 2'(SYNC_TO_FRAME - 1));
  wire  boundary = cclk_fall & (dly_done | (~pend_q & ch_q == 2'(NUM_CH - 1)));
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ch_q      <= 2'h0;
      dly_q     <= 2'h0;
      pend_q    <= 1'b0;
      aligned_q <= 1'b0;
      up_q      <= 5'h0;
      frame_q   <= 1'b0;
    end else if (clk_en) begin
      if (sync_evt) begin
        pend_q <= 1'b1;
        dly_q  <= 2'h0;
      end else if (cclk_fall & pend_q & ~dly_done) begin
        dly_q <= dly_q + 2'h1;
      end else if (boundary & pend_q) begin
        pend_q    <= 1'b0;
        aligned_q <= 1'b1;
      end
      if (cclk_fall) begin
        ch_q <= boundary ? 2'h0 : ch_q + 2'h1;
        if (up_q != 5'(STARTUP_PERIODS)) up_q <= up_q + 5'h1;
      end
      if (cclk_rise) frame_q <= 1'b0;
      else if (boundary) frame_q <= 1'b1;
    end
  end
  // Clock-stop watchdog: no falling edge for many cycles marks outputs invalid.
  logic [7:0] idle_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) idle_q <= 8'h00;
    else if (clk_en) begin
      if (cclk_fall) idle_q <= 8'h00;
      else if (idle_q != 8'hFF) idle_q <= idle_q + 8'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Calibration counts only when all four scattered enables are set at once.
  wire cal_all = calfmt_q[BIT_GAIN_CAL_1] & gca_q[BIT_GAIN_CAL_2]
               & gca_q[BIT_GAIN_CAL_3] & gcb_q[BIT_GAIN_CAL_4];
  // Outputs are only trusted once start-up has run and the clock still moves.
  wire run_ok  = (up_q == 5'(STARTUP_PERIODS)) & (idle_q != 8'hFF);
  // Settings other than ref_enabled are shadowed at the frame boundary so a frame never mixes them.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      twos_comp       <= 1'b0;
      gain_cal_active <= 1'b0;
      ref_enabled     <= 1'b1;
      wide_cm         <= 1'b0;
      cm_sel_a        <= 3'h0;
      cm_sel_b        <= 3'h0;
      span_codes      <= 24'h0;
    end else if (clk_en) begin
      ref_enabled     <= ~ref_q[BIT_REF_OFF];
      if (boundary) begin
        twos_comp       <= calfmt_q[BIT_FORMAT];
        gain_cal_active <= cal_all;
        wide_cm         <= calfmt_q[BIT_WIDE_CM];
        cm_sel_a        <= {calfmt_q[BIT_CM_ON_A], calfmt_q[POS_CM_SPAN_A +: 2]};
        cm_sel_b        <= {calfmt_q[BIT_CM_ON_B], calfmt_q[POS_CM_SPAN_B +: 2]};
        span_codes      <= {span_hi_q[11:0], span_lo_q[11:0]};
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Link outputs are registered so the host samples clean levels only.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lnk.cfg_rdata       <= 16'h0000;
      lnk.frame_clock_out <= 1'b0;
      lnk.out_valid       <= 1'b0;
      lnk.channel_idx     <= 3'h0;
    end else if (clk_en) begin
      lnk.cfg_rdata       <= rd_d;
      lnk.frame_clock_out <= frame_q;
      lnk.out_valid       <= run_ok;
      lnk.channel_idx     <= {1'b0, ch_q};
    end
  end
  // The aligned flag is kept for debug visibility only; nothing downstream
  // depends on it, since an unsynced frame is a legal state.
  wire unused_ok = aligned_q;
endmodule

// ===== afs_host.sv
`timescale 1ns/1ps
module afs_host (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Link to device
  afs_if.host              lnk
);
  import afs_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  // CTRL: bit0 run clock, bit1 issue sync (self-clearing). CFG: bit31 write
  // strobe, [23:16] address, [15:0] data, forwarded to the device port.
  logic        run_q, sync_req_q, cfg_go_q;
  logic [15:0] div_q, cnt_q;
  logic [23:0] cfg_q;
  logic        clk_q, sync_q, req_q, synced_q;
  wire  acc = (avs_read | avs_write) & clk_en;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      run_q        <= 1'b0;
      sync_req_q   <= 1'b0;
      cfg_go_q     <= 1'b0;
      div_q        <= RST_DIV;
      cfg_q        <= 24'h0;
      avs_readdata <= 32'h0;
      req_q        <= 1'b0;
    end else if (clk_en) begin
      req_q    <= acc & ~req_q;
      cfg_go_q <= 1'b0;
      // A write lands at the edge where waitrequest is seen low, never earlier.
      if (acc & req_q & avs_write) begin
        if (avs_address == HOST_CTRL) begin
          run_q <= avs_writedata[0];
          if (avs_writedata[1]) sync_req_q <= 1'b1;
        end else if (avs_address == HOST_DIV) div_q <= avs_writedata[15:0];
        else if (avs_address == HOST_CFG) begin
          cfg_q <= avs_writedata[23:0];
          cfg_go_q <= avs_writedata[31];
        end
      end
      if (acc & ~req_q & avs_read) begin
        if (avs_address == HOST_CTRL) avs_readdata <= {30'h0, sync_req_q, run_q};
        else if (avs_address == HOST_DIV) avs_readdata <= {16'h0, div_q};
        else if (avs_address == HOST_CFG) avs_readdata <= {8'h0, cfg_q};
        else if (avs_address == HOST_STATUS)
          avs_readdata <= {13'h0, lnk.channel_idx, 12'h0,
                           synced_q, lnk.out_valid, lnk.frame_clock_out, run_q};
        else avs_readdata <= 32'h0;
      end
      if (sync_q & clk_q & cnt_q == div_q) sync_req_q <= 1'b0;
    end
  end
  assign avs_waitrequest = ~req_q;
  ////////////////////////////////////////////////////////////////////////////////
  // Conversion clock is divided down and free-running while run is set; sync
  // is raised over one full period around a falling edge.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q    <= 16'h0;
      clk_q    <= 1'b0;
      sync_q   <= 1'b0;
      synced_q <= 1'b0;
    end else if (clk_en) begin
      if (!run_q) cnt_q <= 16'h0;
      else if (cnt_q == div_q) begin
        cnt_q <= 16'h0;
        clk_q <= ~clk_q;
        if (!clk_q) begin
          sync_q <= sync_req_q & ~sync_q;
          if (sync_q) synced_q <= 1'b1;
        end
      end else cnt_q <= cnt_q + 16'h1;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lnk.conversion_clock_in <= 1'b0;
      lnk.sample_align_in     <= 1'b0;
      lnk.cfg_we              <= 1'b0;
      lnk.cfg_addr            <= 8'h0;
      lnk.cfg_wdata           <= 16'h0;
    end else if (clk_en) begin
      lnk.conversion_clock_in <= clk_q;
      lnk.sample_align_in     <= sync_q;
      lnk.cfg_we    <= cfg_go_q;
      lnk.cfg_addr  <= cfg_q[23:16];
      lnk.cfg_wdata <= cfg_q[15:0];
    end
  end
endmodule

// ===== afs_link_asserts.sv
`timescale 1ns/1ps
module afs_link_asserts
  import afs_pkg::*;
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // Link signals
  input wire logic        conversion_clock_in,
  input wire logic        sample_align_in,
  input wire logic        cfg_we,
  input wire logic [7:0]  cfg_addr,
  input wire logic [15:0] cfg_wdata,
  input wire logic [15:0] cfg_rdata,
  input wire logic        frame_clock_out,
  input wire logic        out_valid,
  input wire logic [2:0]  channel_idx
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic       conv_q, frame_q, sync_q, armed_q, synced_q;
  logic [2:0] since_q;
  logic [7:0] falls_q;
  logic [8:0] idle_q;
  logic [1:0] syncs_q;
  ////////////////////////////////////////////////////////////////////////////////
  // Falls are seen here before the device's own synchronizer sees them, so
  // the counts below lead the device's counts and never lag them.
  wire fall = conv_q & ~conversion_clock_in;
  wire cap  = fall & sample_align_in & ~armed_q;
  wire rise = frame_clock_out & ~frame_q;
  wire done = rise & armed_q & (since_q != 3'h0);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {conv_q, frame_q, sync_q, armed_q, synced_q} <= '0;
      {since_q, falls_q, idle_q, syncs_q} <= '0;
    end else begin
      {conv_q, frame_q, sync_q} <= {conversion_clock_in, frame_clock_out, sample_align_in};
      armed_q  <= cap | (armed_q & ~done);
      synced_q <= synced_q | done;
      since_q  <= cap ? 3'h0 : since_q + {2'h0, fall & armed_q & (since_q != 3'h7)};
      idle_q   <= fall ? 9'h0 : idle_q + {8'h0, idle_q != 9'h1FF};
      falls_q  <= (idle_q == 9'd250 && !fall) ? 8'h0 : falls_q + {7'h0, fall & (falls_q != 8'hFF)};
      syncs_q  <= syncs_q + {1'b0, sample_align_in & ~sync_q & (syncs_q != 2'h3)};
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  property rd_back(a, b);
    cfg_we && cfg_addr == a ##1 cfg_addr == a |=> cfg_rdata[b] == $past(cfg_wdata[b], 2);
  endproperty
  sync_to_frame_a: assert property (done |-> since_q inside {3'h3, 3'h4})
    else $error("frame edge not 3 to 4 periods after sync capture");
  frame_chan_zero_a: assert property (rise && (synced_q || done) |-> channel_idx == 3'h0)
    else $error("frame edge not on channel 0");
  valid_startup_a: assert property ($rose(out_valid) |-> falls_q >= 8'(STARTUP_PERIODS))
    else $error("output valid before start-up interval");
  valid_stop_a: assert property (idle_q >= 9'd262 |-> !out_valid)
    else $error("output valid while conversion clock stopped");
  sync_once_a: assert property (syncs_q <= 2'h1)
    else $error("sync pulse repeated");
  cfg_pulse_a: assert property (cfg_we |=> !cfg_we)
    else $error("config write strobe longer than one cycle");
  ref_readback_a: assert property (rd_back(ADDR_REF_POWER, BIT_REF_OFF))
    else $error("reference bit not read back");
  format_readback_a: assert property (rd_back(ADDR_CALIB_FORMAT, BIT_FORMAT))
    else $error("format bit not read back");
  cover property (cap);
  cover property (done);
  cover property ($fell(out_valid));
endmodule

// ===== test_adc_frontend_config_sync.sv
`timescale 1ns/1ps
module test_adc_frontend_config_sync;
  import afs_pkg::*;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic        avs_waitrequest, twos_comp, gain_cal_active, ref_enabled, wide_cm;
  logic [2:0]  cm_sel_a, cm_sel_b;
  logic [23:0] span_codes;
  logic [23:0] exp_span = {SPAN_10V, SPAN_12V, SPAN_2V5, SPAN_3V5,
                           SPAN_5V, SPAN_7V, SPAN_10V, SPAN_12V};
  int          failures = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          c0;
  afs_if afs_if_inst ();
  afs_host afs_host_inst (.clock(clock), .rst_n(rst_n), .clk_en(1'b1),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .lnk(afs_if_inst.host));
  afs_device afs_device_inst (.clock(clock), .rst_n(rst_n), .clk_en(1'b1),
    .lnk(afs_if_inst.dev), .twos_comp(twos_comp), .gain_cal_active(gain_cal_active),
    .ref_enabled(ref_enabled), .wide_cm(wide_cm), .cm_sel_a(cm_sel_a),
    .cm_sel_b(cm_sel_b), .span_codes(span_codes));
  afs_link_asserts afs_link_asserts_inst (.clock(clock), .rst_n(rst_n),
    .conversion_clock_in(afs_if_inst.conversion_clock_in),
    .sample_align_in(afs_if_inst.sample_align_in), .cfg_we(afs_if_inst.cfg_we),
    .cfg_addr(afs_if_inst.cfg_addr), .cfg_wdata(afs_if_inst.cfg_wdata),
    .cfg_rdata(afs_if_inst.cfg_rdata), .frame_clock_out(afs_if_inst.frame_clock_out),
    .out_valid(afs_if_inst.out_valid), .channel_idx(afs_if_inst.channel_idx));
  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // The request stands until waitrequest is sampled low; only the timeout ends a hang.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  task automatic cfg(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, HOST_CFG, {1'b1, 7'h0, a, d});
  endtask
  // Settings other than ref_enabled are shadowed at a frame boundary, so two boundaries make them certain.
  task automatic frames();
    repeat (2) @(posedge afs_if_inst.frame_clock_out);
    repeat (4) @(posedge clock);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    bus(1'b0, HOST_STATUS, 32'h0);
    chk("status", 32'h0, rd);
    bus(1'b0, 4'h1, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b0, HOST_DIV, 32'h0);
    chk("divider", {16'h0, RST_DIV}, rd);
    chk("ref on", 32'h1, 32'(ref_enabled));
    chk("wide cm", 32'h0, 32'(wide_cm));
    $display("reset test done");
  endtask
  task automatic t_start();
    bus(1'b1, HOST_DIV, 32'h4);
    bus(1'b1, HOST_CTRL, 32'h1);
    c0 = cycles;
    bus(1'b0, HOST_STATUS, 32'h0);
    chk("early valid", 32'h0, 32'(rd[2]));
    wait (afs_if_inst.out_valid === 1'b1);
    chk("startup", 32'h1, 32'((cycles - c0) >= (STARTUP_PERIODS - 1) * 10));
    $display("start-up test done");
  endtask
  task automatic t_sync();
    bus(1'b1, HOST_CTRL, 32'h3);
    do bus(1'b0, HOST_STATUS, 32'h0); while (rd[3] !== 1'b1);
    chk("status synced", 32'hD, rd & 32'hD);
    @(posedge afs_if_inst.frame_clock_out);
    #1;
    chk("channel at frame", 32'h0, 32'(afs_if_inst.channel_idx));
    $display("sync test done");
  endtask
  task automatic t_cfg();
    frames();
    cfg(ADDR_CALIB_FORMAT, 16'h00EF);
    repeat (6) @(posedge clock);
    chk("format held", 32'h0, 32'(twos_comp));
    frames();
    chk("format", 32'h1, 32'(twos_comp));
    chk("wide cm set", 32'h1, 32'(wide_cm));
    chk("cm a", 32'({1'b1, CM_MID}), 32'(cm_sel_a));
    chk("cm b", 32'({1'b1, CM_WIDEST}), 32'(cm_sel_b));
    cfg(ADDR_GAIN_CAL_A, 16'h0003);
    cfg(ADDR_CALIB_FORMAT, 16'h000B);
    frames();
    chk("cal partial", 32'h0, 32'(gain_cal_active));
    chk("cm a half", 32'({1'b1, CM_HALF}), 32'(cm_sel_a));
    chk("cm b narrow", 32'h0, 32'(cm_sel_b));
    cfg(ADDR_GAIN_CAL_B, 16'h0001);
    frames();
    chk("cal full", 32'h1, 32'(gain_cal_active));
    $display("config test done");
  endtask
  task automatic t_span();
    cfg(ADDR_SPAN_LO, {4'h0, exp_span[11:0]});
    cfg(ADDR_SPAN_HI, {4'h0, exp_span[23:12]});
    cfg(ADDR_REF_POWER, 16'h0001);
    frames();
    chk("spans", 32'(exp_span), 32'(span_codes));
    chk("ref off", 32'h0, 32'(ref_enabled));
    $display("span test done");
  endtask
  task automatic t_stop();
    bus(1'b1, HOST_CTRL, 32'h0);
    repeat (300) @(posedge clock);
    bus(1'b0, HOST_STATUS, 32'h0);
    chk("valid stopped", 32'h0, 32'(rd[2]));
    $display("stop test done");
  endtask
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_start();
    t_sync();
    t_cfg();
    t_span();
    t_stop();
    wrap_up();
  end
endmodule
